// ### core/ilb_pkg.sv
// Shared constants, state codes and the controller state record for the live-insertion buffer.
package ilb_pkg;

    // Reference clock period and bus idle time, both in nanoseconds.
    localparam int CLK_PERIOD_NS   = 5;
    localparam int IDLE_TIME_NS    = 95000;
    // A least time, so the cycle count rounds up.
    localparam int IDLE_CYCLES_DEF = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Cycles to ignore the far side after releasing a drive: two sync stages plus the output register.
    localparam logic [1:0] HOLD_CYCLES = 2'h3;

    // Bit positions inside the synchroniser vectors.
    localparam int SY_BP_DATA  = 0;
    localparam int SY_BP_CLOCK = 1;
    localparam int SY_CD_DATA  = 2;
    localparam int SY_CD_CLOCK = 3;
    localparam int SY_LOCKOUT  = 4;
    localparam int SY_SENSE    = 5;
    localparam int SY_W        = 6;

    // Bit positions inside a drive pair.
    localparam int DRV_BP = 1;
    localparam int DRV_CD = 0;

    // Values after reset.
    localparam logic [SY_W-1:0] SYNC_RST  = 6'h1f;
    localparam logic            READY_RST = 1'h1;

    typedef enum logic [1:0] {
        ILB_ST_LOCK = 2'b00,
        ILB_ST_WAIT = 2'b01,
        ILB_ST_CONN = 2'b10,
        ILB_ST_ISO  = 2'b11
    } ilb_state_t;

    typedef struct packed {
        logic [SY_W-1:0] sync1;
        logic [SY_W-1:0] sync2;
        ilb_state_t      state;
        logic            need_card;
        logic            bp_seen;
        logic            card_seen;
        logic [1:0]      drv_data;
        logic [1:0]      drv_clock;
        logic [1:0]      hold_data;
        logic [1:0]      hold_clock;
        logic            ready_pull;
        logic            drive_level;
    } ilb_ctrl_state_t;

endpackage : ilb_pkg

// ### core/ilb_cond_if.sv
// Carrier between the controller and one stop-or-idle detector.
`timescale 1ns/10ps
`default_nettype none

interface ilb_cond_if;
    logic data;
    logic clock;
    logic arm;
    logic event_p;

    modport det (
        input  data,
        input  clock,
        input  arm,
        output event_p
    );

    modport user (
        output data,
        output clock,
        output arm,
        input  event_p
    );
endinterface : ilb_cond_if

`default_nettype wire

// ### core/ilb_cond_det.sv
// Stop-condition and bus-idle detector for one synchronised line pair.
`timescale 1ns/10ps
`default_nettype none

module ilb_cond_det
    import ilb_pkg::*;
#(
    parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    ilb_cond_if.det  lines
);

    localparam int CNT_W = $clog2(IDLE_CYCLES + 1);

    if (IDLE_CYCLES < 2)
    begin : g_bad_idle
        $error("IDLE_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic             prev_data;
        logic [CNT_W-1:0] cnt;
        logic             event_p;
    } ilb_det_state_t;

    ilb_det_state_t cur_ff;
    ilb_det_state_t nxt_cur;

    localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(IDLE_CYCLES);

    always_comb
    begin
        nxt_cur           = cur_ff;
        nxt_cur.prev_data = lines.data;
        nxt_cur.event_p   = 1'b0;
        if (!lines.arm || !(lines.data && lines.clock))
        begin
            nxt_cur.cnt = '0;
        end
        else if (cur_ff.cnt != CNT_TOP)
        begin
            nxt_cur.cnt = cur_ff.cnt + CNT_W'(1);
        end
        if (lines.arm)
        begin
            // Stop: data rises while clock stays high.
            if (!cur_ff.prev_data && lines.data && lines.clock)
            begin
                nxt_cur.event_p = 1'b1;
            end
            // Idle: both lines high for the full count.
            if (lines.data && lines.clock && cur_ff.cnt == CNT_TOP - CNT_W'(1))
            begin
                nxt_cur.event_p = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_ff <= '{prev_data: 1'b1, cnt: '0, event_p: 1'b0};
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign lines.event_p = cur_ff.event_p;

endmodule : ilb_cond_det

`default_nettype wire

// ### core/ilb_ctrl.sv
// Live-insertion connection controller for a two-wire bus buffer.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Lockout ignores lines and keeps segments apart.
// - After lockout, wait for backplane stop or idle.
// - Connect only if card data and clock high.
// - Connected: a low on one side propagates across.
// - Pair rises only when all drivers release, except the short pulse on the owning side noted at the pair function.
// - Sense high isolates both pairs, pulls ready low.
// - Ready high only when sensed low and started.
// - After sense drops, requalify both sides first.
// - Ready releases on the same edge as reconnection.
// - Isolated segments pass no low level across.
module ilb_ctrl
    import ilb_pkg::*;
#(
    parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
)
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic supply_lockout,
    input  wire logic conn_sense,
    input  wire logic backplane_data_line_i,
    output var  logic backplane_data_line_o,
    output var  logic backplane_data_line_oe,
    input  wire logic backplane_clock_line_i,
    output var  logic backplane_clock_line_o,
    output var  logic backplane_clock_line_oe,
    input  wire logic card_data_line_i,
    output var  logic card_data_line_o,
    output var  logic card_data_line_oe,
    input  wire logic card_clock_line_i,
    output var  logic card_clock_line_o,
    output var  logic card_clock_line_oe,
    output var  logic ready_o,
    output var  logic ready_oe
);

    if (IDLE_CYCLES < 2)
    begin : g_bad_idle
        $error("IDLE_CYCLES must be at least 2");
    end

    if (HOLD_CYCLES < 2'h3)
    begin : g_bad_hold
        $error("HOLD_CYCLES must cover both sync stages and the output register");
    end

    if (SYNC_RST[SY_LOCKOUT] != 1'b1)
    begin : g_bad_sync_rst
        $error("The lockout stage must reset high so the block starts locked out");
    end

    if (SY_W != 6)
    begin : g_bad_sync_w
        $error("The synchroniser vector must hold exactly the six sampled pins");
    end

    ilb_ctrl_state_t cur_ff;
    ilb_ctrl_state_t nxt_cur;

    ilb_cond_if bp_if ();
    ilb_cond_if cd_if ();

    // One wired-AND pair: whichever side went low first owns the pull on the other side.
    // After our own pull is released the far side is ignored for a few cycles, because the
    // synchronised copy still shows the low that we made ourselves and would latch the pair.
    // Limitation: if outside drivers hold both sides low, the side that went low first (the backplane on a tie) owns the pull;
    // when it lets go, the other side's own low reappears on the owning side only after the hold,
    // so the owning side shows a short high pulse.
    function automatic logic [3:0] ilb_pair_next(
        input logic       connected,
        input logic       bp_line,
        input logic       cd_line,
        input logic [1:0] drv,
        input logic [1:0] hold
    );
        logic [1:0] nd;
        logic [1:0] nh;
        nd = 2'b00;
        nh = (hold != 2'h0) ? hold - 2'h1 : 2'h0;
        if (!connected)
        begin
            nd = 2'b00;
            nh = 2'h0;
        end
        else if (drv[DRV_CD])
        begin
            // Held until the backplane side is released by everyone.
            nd[DRV_CD] = !bp_line;
            nh         = bp_line ? HOLD_CYCLES : 2'h0;
        end
        else if (drv[DRV_BP])
        begin
            nd[DRV_BP] = !cd_line;
            nh         = cd_line ? HOLD_CYCLES : 2'h0;
        end
        else if (hold == 2'h0)
        begin
            if (!bp_line)
            begin
                nd[DRV_CD] = 1'b1;
            end
            else if (!cd_line)
            begin
                nd[DRV_BP] = 1'b1;
            end
        end
        return {nd, nh};
    endfunction : ilb_pair_next

    // The detectors listen and the sticky flags live only while qualifying.
    function automatic logic ilb_qualifying(
        input ilb_state_t st
    );
        return (st == ILB_ST_WAIT);
    endfunction : ilb_qualifying

    // Synchronised copies; only the second stage is read by any logic.
    logic bp_data;
    logic bp_clock;
    logic cd_data;
    logic cd_clock;
    logic lockout;
    logic sense;

    assign bp_data  = cur_ff.sync2[SY_BP_DATA];
    assign bp_clock = cur_ff.sync2[SY_BP_CLOCK];
    assign cd_data  = cur_ff.sync2[SY_CD_DATA];
    assign cd_clock = cur_ff.sync2[SY_CD_CLOCK];
    assign lockout  = cur_ff.sync2[SY_LOCKOUT];
    assign sense    = cur_ff.sync2[SY_SENSE];

    // Detectors listen only while qualifying, so activity during lockout is ignored.
    assign bp_if.data  = bp_data;
    assign bp_if.clock = bp_clock;
    assign bp_if.arm   = ilb_qualifying(cur_ff.state);
    assign cd_if.data  = cd_data;
    assign cd_if.clock = cd_clock;
    assign cd_if.arm   = ilb_qualifying(cur_ff.state) && cur_ff.need_card;

    ilb_cond_det #(
        .IDLE_CYCLES (IDLE_CYCLES)
    ) u_bp_det (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .lines   (bp_if.det)
    );

    ilb_cond_det #(
        .IDLE_CYCLES (IDLE_CYCLES)
    ) u_cd_det (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .lines   (cd_if.det)
    );

    logic qualified;
    logic [3:0] pair_data;
    logic [3:0] pair_clock;
    logic conn_next;

    always_comb
    begin
        nxt_cur       = cur_ff;
        // Bit order follows the synchroniser positions in the package.
        nxt_cur.sync1 = {
            conn_sense,
            supply_lockout,
            card_clock_line_i,
            card_data_line_i,
            backplane_clock_line_i,
            backplane_data_line_i
        };
        nxt_cur.sync2 = cur_ff.sync1;
        nxt_cur.drive_level = 1'b0;

        // Events set the sticky flags; a clear in the same cycle wins.
        nxt_cur.bp_seen   = cur_ff.bp_seen | bp_if.event_p;
        nxt_cur.card_seen = cur_ff.card_seen | cd_if.event_p;

        qualified = (cur_ff.bp_seen || bp_if.event_p)
                    && (!cur_ff.need_card || cur_ff.card_seen || cd_if.event_p);

        case (cur_ff.state)
            ILB_ST_LOCK:
            begin
                if (!lockout)
                begin
                    nxt_cur.state     = sense ? ILB_ST_ISO : ILB_ST_WAIT;
                    nxt_cur.need_card = 1'b0;
                end
            end
            ILB_ST_WAIT:
            begin
                if (sense)
                begin
                    nxt_cur.state = ILB_ST_ISO;
                end
                else if (qualified && cd_data && cd_clock)
                begin
                    nxt_cur.state = ILB_ST_CONN;
                end
            end
            ILB_ST_CONN:
            begin
                if (sense)
                begin
                    nxt_cur.state = ILB_ST_ISO;
                end
            end
            ILB_ST_ISO:
            begin
                if (!sense)
                begin
                    // The card may have been mid-transfer as well, so its detector is armed too.
                    nxt_cur.state     = ILB_ST_WAIT;
                    nxt_cur.need_card = 1'b1;
                end
            end
            default:
            begin
                nxt_cur.state = ILB_ST_LOCK;
            end
        endcase

        // Lockout overrides every state and drops all qualification.
        if (lockout)
        begin
            nxt_cur.state = ILB_ST_LOCK;
        end

        if (!ilb_qualifying(nxt_cur.state))
        begin
            nxt_cur.bp_seen   = 1'b0;
            nxt_cur.card_seen = 1'b0;
        end
        else if (!ilb_qualifying(cur_ff.state))
        begin
            nxt_cur.bp_seen   = bp_if.event_p;
            nxt_cur.card_seen = cd_if.event_p;
        end

        // A pin change shows in the second sync stage two edges later, and the state and
        // drive registers move on the third edge. Ready and the joint enables come from one
        // next state, so they can never disagree, not even for a single cycle.
        // Drives and ready follow the next state, so ready and the joint change on one edge.
        conn_next  = (nxt_cur.state == ILB_ST_CONN);
        pair_data  = ilb_pair_next(conn_next, bp_data, cd_data, cur_ff.drv_data, cur_ff.hold_data);
        pair_clock = ilb_pair_next(conn_next, bp_clock, cd_clock, cur_ff.drv_clock, cur_ff.hold_clock);
        nxt_cur.drv_data   = pair_data[3:2];
        nxt_cur.hold_data  = pair_data[1:0];
        nxt_cur.drv_clock  = pair_clock[3:2];
        nxt_cur.hold_clock = pair_clock[1:0];
        nxt_cur.ready_pull = !conn_next;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_ff <= '{
                sync1:       SYNC_RST,
                sync2:       SYNC_RST,
                state:       ILB_ST_LOCK,
                need_card:   1'b0,
                bp_seen:     1'b0,
                card_seen:   1'b0,
                drv_data:    2'b00,
                drv_clock:   2'b00,
                hold_data:   2'h0,
                hold_clock:  2'h0,
                ready_pull:  READY_RST,
                drive_level: 1'b0
            };
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // Every pin output is a flip-flop; the level is a constant low, only the enables move.
    assign backplane_data_line_o   = cur_ff.drive_level;
    assign backplane_clock_line_o  = cur_ff.drive_level;
    assign card_data_line_o        = cur_ff.drive_level;
    assign card_clock_line_o       = cur_ff.drive_level;
    assign ready_o                 = cur_ff.drive_level;
    assign backplane_data_line_oe  = cur_ff.drv_data[DRV_BP];
    assign card_data_line_oe       = cur_ff.drv_data[DRV_CD];
    assign backplane_clock_line_oe = cur_ff.drv_clock[DRV_BP];
    assign card_clock_line_oe      = cur_ff.drv_clock[DRV_CD];
    assign ready_oe                = cur_ff.ready_pull;

endmodule : ilb_ctrl

`default_nettype wire

// ### verification/ilb_ctrl_properties.sv
// Pin-level checker for the live-insertion connection controller.
`timescale 1ns/10ps
`default_nettype none
module ilb_ctrl_checker #(
    parameter int IDLE_CYCLES = 19000
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic supply_lockout,
    input wire logic conn_sense,
    input wire logic backplane_data_line_i,
    input wire logic card_data_line_i,
    input wire logic card_clock_line_i,
    input wire logic backplane_data_line_oe,
    input wire logic backplane_clock_line_oe,
    input wire logic card_data_line_oe,
    input wire logic card_clock_line_oe,
    input wire logic ready_oe
);
    logic any_oe;
    assign any_oe = backplane_data_line_oe | backplane_clock_line_oe | card_data_line_oe | card_clock_line_oe;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Windows allow two sync stages plus the output register.
    property p_lock;
        supply_lockout [*5] |-> !any_oe && ready_oe;
    endproperty
    a_lock: assert property (p_lock) else $error("line pulled during lockout");
    property p_sense;
        conn_sense [*5] |-> !any_oe && ready_oe;
    endproperty
    a_sense: assert property (p_sense) else $error("sense high but not isolated");
    property p_iso;
        ready_oe [*4] |-> !any_oe;
    endproperty
    a_iso: assert property (p_iso) else $error("low passed while isolated");
    property p_ready;
        !ready_oe |-> !$past(conn_sense, 4) && !$past(supply_lockout, 4);
    endproperty
    a_ready: assert property (p_ready) else $error("ready released too early");
    property p_join;
        $fell(ready_oe) |-> $past(card_data_line_i, 3) && $past(card_clock_line_i, 3);
    endproperty
    a_join: assert property (p_join) else $error("joined with a card line low");
    property p_d_pass;
        (!ready_oe && !backplane_data_line_oe && !backplane_data_line_i) [*7] |-> card_data_line_oe;
    endproperty
    a_d_pass: assert property (p_d_pass) else $error("data low not passed to card");
    property p_c_pass;
        (!ready_oe && !card_clock_line_oe && !card_clock_line_i) [*7] |-> backplane_clock_line_oe;
    endproperty
    a_c_pass: assert property (p_c_pass) else $error("clock low not passed to backplane");
    property p_rise;
        $fell(card_data_line_oe) && !ready_oe |-> $past(backplane_data_line_i, 3);
    endproperty
    a_rise: assert property (p_rise) else $error("card data released early");
    property p_oe_ready;
        any_oe |-> !ready_oe;
    endproperty
    a_oe_ready: assert property (p_oe_ready) else $error("line pulled while ready still held low");
    c_connect: cover property ($fell(ready_oe));
    c_isolate: cover property ($rose(ready_oe));
    c_pass: cover property ($rose(card_data_line_oe));
endmodule : ilb_ctrl_checker
bind ilb_ctrl ilb_ctrl_checker #(.IDLE_CYCLES(IDLE_CYCLES)) chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .supply_lockout(supply_lockout), .conn_sense(conn_sense),
    .backplane_data_line_i(backplane_data_line_i), .card_data_line_i(card_data_line_i),
    .card_clock_line_i(card_clock_line_i), .backplane_data_line_oe(backplane_data_line_oe),
    .backplane_clock_line_oe(backplane_clock_line_oe), .card_data_line_oe(card_data_line_oe),
    .card_clock_line_oe(card_clock_line_oe), .ready_oe(ready_oe));
`default_nettype wire

// ### verification/ilb_bus_partner.sv
// Open-drain model of the controllers and targets on both bus segments.
`timescale 1ns/10ps
`default_nettype none
module ilb_bus_partner
(
    output var logic bp_d,
    output var logic bp_c,
    output var logic cd_d,
    output var logic cd_c
);
    // High means this party pulls its line low; a released line rises on its pull-up.
    initial
    begin
        {bp_d, bp_c, cd_d, cd_c} = 4'h0;
    end
    // The backplane clock runs at 48 ns only inside a frame and rests high between frames.
    task automatic frame(input int n);
        repeat (n)
        begin
            bp_c = 1'b1;
            #24;
            bp_c = 1'b0;
            #24;
        end
    endtask : frame
    task automatic noise(inout int s);
        repeat (40)
        begin
            #7;
            {bp_d, bp_c, cd_d, cd_c} = 4'($random(s));
        end
        {bp_d, bp_c, cd_d, cd_c} = 4'h0;
    endtask : noise
endmodule : ilb_bus_partner
`default_nettype wire

// ### verification/ilb_ctrl_test.sv
// Self-checking bench for the live-insertion connection controller.
`timescale 1ns/10ps
`default_nettype none
module ilb_ctrl_test;
    logic ref_clk, rst_n, supply_lockout, conn_sense, ready_seen;
    wire logic bp_data, bp_clock, card_data, card_clock;
    logic bd_o, bd_oe, bc_o, bc_oe, kd_o, kd_oe, kc_o, kc_oe, rdy_o, ready_oe;
    logic bp_d, bp_c, cd_d, cd_c;
    logic exp_q[$];
    int seed, bad_count, compares;
    assign bp_data = ~(bd_oe & ~bd_o) & ~bp_d;
    assign bp_clock = ~(bc_oe & ~bc_o) & ~bp_c;
    assign card_data = ~(kd_oe & ~kd_o) & ~cd_d;
    assign card_clock = ~(kc_oe & ~kc_o) & ~cd_c;
    ilb_ctrl #(.IDLE_CYCLES(20)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .supply_lockout(supply_lockout),
        .conn_sense(conn_sense), .backplane_data_line_i(bp_data), .backplane_data_line_o(bd_o),
        .backplane_data_line_oe(bd_oe), .backplane_clock_line_i(bp_clock), .backplane_clock_line_o(bc_o),
        .backplane_clock_line_oe(bc_oe), .card_data_line_i(card_data), .card_data_line_o(kd_o),
        .card_data_line_oe(kd_oe), .card_clock_line_i(card_clock), .card_clock_line_o(kc_o),
        .card_clock_line_oe(kc_oe), .ready_o(rdy_o), .ready_oe(ready_oe));
    ilb_bus_partner pm (.bp_d(bp_d), .bp_c(bp_c), .cd_d(cd_d), .cd_c(cd_c));
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic seen, input logic exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic wait_ready(input logic v);
        int n;
        n = 0;
        // Look a step after each edge, once the registered pin has settled.
        while (ready_oe !== v && n < 400)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (ready_oe !== v)
        begin
            bad_count++;
            tally_and_finish();
        end
    endtask : wait_ready
    // Every movement of the ready pull-down must match the oldest note.
    always @(negedge ref_clk)
    begin
        if (rst_n === 1'b1 && ready_oe !== ready_seen)
        begin
            if (exp_q.size() == 0) check("ready_oe", ready_oe, ready_seen);
            else check("ready_oe", ready_oe, exp_q.pop_front());
        end
        ready_seen = ready_oe;
    end
    initial
    begin
        seed = 59948;
        rst_n = 1'b0;
        supply_lockout = 1'b1;
        conn_sense = 1'b0;
        ready_seen = 1'b1;
        bad_count = 0;
        compares = 0;
        cyc(8);
        rst_n = 1'b1;
        pm.noise(seed);
        cyc(6);
        check("line_oe", bd_oe | bc_oe | kd_oe | kc_oe, 1'b0);
        check("ready_oe", ready_oe, 1'b1);
        // Data held low through a frame gives neither a stop nor an idle.
        supply_lockout = 1'b0;
        pm.bp_d = 1'b1;
        pm.frame(6);
        cyc(2);
        check("ready_oe", ready_oe, 1'b1);
        pm.cd_c = 1'b1;
        cyc(4);
        pm.bp_d = 1'b0;
        cyc(40);
        check("ready_oe", ready_oe, 1'b1);
        exp_q.push_back(1'b0);
        pm.cd_c = 1'b0;
        wait_ready(1'b0);
        check("card_lines", card_data & card_clock, 1'b1);
        pm.bp_d = 1'b1;
        cyc(8);
        check("card_data_line_oe", kd_oe, 1'b1);
        check("backplane_clock_line_oe", bc_oe, 1'b0);
        pm.cd_d = 1'b1;
        pm.bp_d = 1'b0;
        cyc(10);
        check("backplane_data", bp_data, 1'b0);
        pm.cd_d = 1'b0;
        cyc(10);
        check("both_data", bp_data & card_data, 1'b1);
        pm.cd_c = 1'b1;
        cyc(8);
        check("backplane_clock_line_oe", bc_oe, 1'b1);
        pm.cd_c = 1'b0;
        cyc(8);
        check("backplane_clock_line_oe", bc_oe, 1'b0);
        // Isolation must act while a low is being carried across.
        pm.bp_d = 1'b1;
        cyc(8);
        exp_q.push_back(1'b1);
        conn_sense = 1'b1;
        wait_ready(1'b1);
        check("line_oe", bd_oe | bc_oe | kd_oe | kc_oe, 1'b0);
        pm.cd_d = 1'b1;
        cyc(8);
        check("line_oe", bd_oe | kd_oe, 1'b0);
        pm.bp_d = 1'b0;
        conn_sense = 1'b0;
        cyc(60);
        check("ready_oe", ready_oe, 1'b1);
        exp_q.push_back(1'b0);
        pm.cd_d = 1'b0;
        wait_ready(1'b0);
        pm.bp_d = 1'b1;
        cyc(4);
        check("card_data_line_oe", kd_oe, 1'b1);
        check("line_o", bd_o | bc_o | kd_o | kc_o | rdy_o, 1'b0);
        pm.bp_d = 1'b0;
        cyc(5);
        check("pending", exp_q.size() == 0, 1'b1);
        tally_and_finish();
    end
endmodule : ilb_ctrl_test
`default_nettype wire
